// ===== design/adc_ctrl_pkg.sv
// package: register map, field positions, reset values and timing counts
package adc_ctrl_pkg;
    // register word indexes (byte address is four times the index)
    localparam logic [13:0] IDX_MAIN = 14'h1D26;
    localparam logic [13:0] IDX_GUARD = 14'h1D27;
    localparam logic [13:0] IDX_COMP = 14'h1D28;
    localparam logic [13:0] IDX_PRE = 14'h1D30;
    localparam logic [13:0] IDX_CLKDIV = 14'h1D31;
    localparam logic [13:0] IDX_AUX = 14'h1D32;
    localparam logic [13:0] IDX_RES_L = 14'h1D33;
    localparam logic [13:0] IDX_RES_H = 14'h1D34;
    localparam logic [13:0] IDX_PREV_L = 14'h1D35;
    localparam logic [13:0] IDX_PREV_H = 14'h1D36;
    localparam logic [13:0] IDX_FILT_L = 14'h1D37;
    localparam logic [13:0] IDX_FILT_H = 14'h1D38;
    localparam logic [13:0] IDX_STAT = 14'h1D39;
    // converter_control_main fields
    localparam int BIT_ON = 7;
    localparam int BIT_CONTINUOUS_RETRIGGER = 6;
    localparam int BIT_CS = 4;
    localparam int BIT_FM = 2;
    localparam int BIT_IC = 1;
    localparam int BIT_GO = 0;
    // precharge_guard_control fields
    localparam int BIT_PRECHARGE_POLARITY = 7;
    localparam int BIT_INVERTED_PRECHARGE_EN = 6;
    localparam int BIT_GUARD_POLARITY = 5;
    localparam int BIT_PRECHARGE_CAP_ONLY = 1;
    localparam int BIT_DOUBLE_SAMPLE_EN = 0;
    // computation_control fields
    localparam int BIT_PREV_SOURCE_SEL = 7;
    localparam int BIT_CRS = 4;
    localparam int BIT_ACCUM_CLEAR = 3;
    localparam int BIT_MD = 0;
    // auxiliary and status fields
    localparam int BIT_SOI = 0;
    localparam int BIT_IRQ = 0;
    localparam int BIT_AOV = 1;
    localparam int BIT_STAGE = 2;
    localparam int BIT_SECOND = 5;
    // reset values
    localparam logic [7:0] RST_MAIN = 8'h02;
    localparam logic [7:0] RST_GUARD = 8'h00;
    localparam logic [7:0] RST_COMP = 8'h00;
    localparam logic [7:0] RST_PRE = 8'h00;
    localparam logic [5:0] RST_CLKDIV = 6'h00;
    // timing in conversion-clock ticks
    localparam logic [7:0] ACQ_TICKS = 8'h04;
    localparam logic [3:0] LAST_BIT = 4'hB;
    // operating modes
    typedef enum logic [2:0] {
        MD_BASIC = 3'b000,
        MD_ACCUM = 3'b001,
        MD_AVG = 3'b010,
        MD_BURST = 3'b011,
        MD_LPF = 3'b100
    } mode_t;
    // conversion stages
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PRE = 2'b01,
        ST_ACQ = 2'b10,
        ST_CONV = 2'b11
    } stage_t;
endpackage

// ===== design/adc_ctrl.sv
// converter control and configuration block with a wishbone register slave
//
// Overview of operation
// - enable bit turns converter on, gates starts
// - writing go starts cycle; reads one meanwhile
// - continuous mode restarts until cleared or threshold
// - one-shot mode clears go after each conversion
// - go cleared midway: partial result, no flag
// - clock from rc oscillator or divided system
// - single-ended: x1 right, x0 left justified
// - differential: four sign and justify formats
// - input config selects differential, resets one
// - precharge polarity sets pin and cap levels
// - inverted precharge flips second sample polarities
// - guard outputs start at guard polarity; A starts inverted with zero precharge time
// - cap-only precharge leaves the pin alone
// - double sampling computes after every pair
// - previous result, or filter output if selected, loaded at conversion start
// - low-pass filter constant two to shift
// - accumulate modes shift result right
// - basic and reserved modes ignore shift
// - accumulator clear clears state, self-clears
// - mode field selects the computation mode
// - zero precharge time skips precharge stage
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ps
module adc_ctrl (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    // wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [15:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // analog front end
    input wire logic RC_OSC_IN,
    input wire logic COMP_BIT_IN,
    input wire logic THRESH_IRQ_IN,
    output logic CONV_ACTIVE,
    output logic CAP_PRECHARGE,
    output logic CAP_LEVEL,
    output logic SAMPLE_CONNECT,
    output logic ANA_PIN_O,
    output logic ANA_PIN_OE_N,
    output logic GUARD_A,
    output logic GUARD_B
);
    import adc_ctrl_pkg::*;

    // every flip-flop of the block
    typedef struct packed {
        logic ack;
        logic [7:0] rdata;
        logic on;
        logic continuous_retrigger;
        logic cs;
        logic [1:0] fm;
        logic ic;
        logic go;
        logic precharge_polarity;
        logic inverted_precharge_en;
        logic guard_polarity;
        logic precharge_cap_only;
        logic double_sample_en;
        logic prev_source_sel;
        logic [2:0] crs;
        logic accum_clear;
        logic [2:0] md;
        logic stop_on_interrupt;
        logic [7:0] pre_time;
        logic [5:0] clk_div;
        stage_t stage;
        logic second;
        logic [7:0] tick_cnt;
        logic [5:0] div_cnt;
        logic [11:0] raw;
        logic [3:0] bit_cnt;
        logic [15:0] result;
        logic [15:0] prev;
        logic [15:0] filt;
        logic [17:0] acc;
        logic [7:0] cnt;
        logic accum_overflow;
        logic irq;
        logic done;
        logic rc_s1;
        logic rc_s2;
        logic rc_s3;
        logic cmp_s1;
        logic cmp_s2;
        logic cap_pre;
        logic cap_lvl;
        logic smp_con;
        logic pin_o;
        logic pin_oe_n;
        logic grd_a;
        logic grd_b;
    } state_t;

    state_t q; // registered state
    state_t d; // next state
    logic [13:0] idx; // word index of the bus address
    logic req; // bus request present
    logic wr; // write takes effect this edge
    logic [7:0] wdat; // write byte
    logic tick; // conversion clock tick
    logic do_start; // begin a conversion this cycle
    logic pol; // precharge polarity of the starting sample
    logic gpl; // guard polarity of the starting sample
    logic [11:0] raw_n; // raw word with the newest bit
    logic [18:0] acc_sum; // accumulator plus result with carry
    logic signed [16:0] lp_diff; // filter error term
    logic signed [16:0] lp_step; // filter error after shift
    logic irq_ev; // a completion sets the flag this cycle

    assign idx = WB_ADR_I[15:2];

    // result formatting by input configuration and format code
    function automatic logic [15:0] fmt(input logic [11:0] r,
                                        input logic ic,
                                        input logic [1:0] fm);
        logic [11:0] mag;
        logic [15:0] o;
        mag = r[11] ? 12'(~r + 12'h001) : r;
        if (!ic) begin
            o = fm[0] ? {4'h0, r} : {r, 4'h0};
        end else begin
            case (fm)
                2'b11: o = {r[11], 3'h0, mag};
                2'b10: o = {r[11], mag[10:0], 4'h0};
                2'b01: o = {{4{r[11]}}, r};
                default: o = {r, 4'h0};
            endcase
        end
        return o;
    endfunction

    // register readback; unimplemented bits are zero
    function automatic logic [7:0] rd_reg(input state_t s,
                                          input logic [13:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a == IDX_MAIN) begin
            v = {s.on, s.continuous_retrigger, 1'b0, s.cs, s.fm, s.ic, s.go};
        end else if (a == IDX_GUARD) begin
            v = {s.precharge_polarity, s.inverted_precharge_en, s.guard_polarity, 3'h0, s.precharge_cap_only, s.double_sample_en};
        end else if (a == IDX_COMP) begin
            v = {s.prev_source_sel, s.crs, s.accum_clear, s.md};
        end else if (a == IDX_PRE) begin
            v = s.pre_time;
        end else if (a == IDX_CLKDIV) begin
            v = {2'h0, s.clk_div};
        end else if (a == IDX_AUX) begin
            v = {7'h00, s.stop_on_interrupt};
        end else if (a == IDX_RES_L) begin
            v = s.result[7:0];
        end else if (a == IDX_RES_H) begin
            v = s.result[15:8];
        end else if (a == IDX_PREV_L) begin
            v = s.prev[7:0];
        end else if (a == IDX_PREV_H) begin
            v = s.prev[15:8];
        end else if (a == IDX_FILT_L) begin
            v = s.filt[7:0];
        end else if (a == IDX_FILT_H) begin
            v = s.filt[15:8];
        end else if (a == IDX_STAT) begin
            v = {2'h0, s.second, 1'b0, s.stage, s.accum_overflow, s.irq};
        end
        return v;
    endfunction

    // next-state logic: bus slave, conversion sequencer, computation
    always_comb begin
        d = q;
        do_start = 1'b0;
        wdat = WB_DAT_I[7:0];
        req = WB_CYC_I && WB_STB_I;
        wr = req && q.ack && WB_WE_I && WB_SEL_I[0];
        d.done = 1'b0;
        irq_ev = 1'b0;
        // synchronisers for pins from the analog side
        d.rc_s1 = RC_OSC_IN;
        d.rc_s2 = q.rc_s1;
        d.rc_s3 = q.rc_s2;
        d.cmp_s1 = COMP_BIT_IN;
        d.cmp_s2 = q.cmp_s1;
        // ack one cycle after the request, dropped the cycle after
        d.ack = req && !q.ack;
        if (req && !q.ack) begin
            d.rdata = rd_reg(q, idx);
        end
        // conversion clock from rc edges or the system divider
        if (q.div_cnt >= q.clk_div) begin
            d.div_cnt = 6'h00;
        end else begin
            d.div_cnt = 6'(q.div_cnt + 6'h01);
        end
        if (q.cs) begin
            tick = q.rc_s2 && !q.rc_s3;
        end else begin
            tick = (q.div_cnt >= q.clk_div);
        end
        raw_n = {q.raw[10:0], q.cmp_s2};
        // accumulator clear finishes one cycle after it is requested
        if (q.accum_clear) begin
            d.acc = 18'h00000;
            d.cnt = 8'h00;
            d.accum_overflow = 1'b0;
            d.accum_clear = 1'b0;
        end
        // sequencer, advanced on conversion clock ticks
        if (q.stage != ST_IDLE && tick) begin
            case (q.stage)
                ST_PRE: begin
                    if (q.tick_cnt <= 8'h01) begin
                        d.stage = ST_ACQ;
                        d.tick_cnt = ACQ_TICKS;
                        d.cap_pre = 1'b0;
                        d.pin_oe_n = 1'b1;
                        d.smp_con = 1'b1;
                        d.grd_a = ~q.grd_a;
                    end else begin
                        d.tick_cnt = 8'(q.tick_cnt - 8'h01);
                    end
                end
                ST_ACQ: begin
                    if (q.tick_cnt <= 8'h01) begin
                        d.stage = ST_CONV;
                        d.bit_cnt = 4'h0;
                        d.smp_con = 1'b0;
                    end else begin
                        d.tick_cnt = 8'(q.tick_cnt - 8'h01);
                    end
                end
                ST_CONV: begin
                    d.raw = raw_n;
                    d.bit_cnt = 4'(q.bit_cnt + 4'h1);
                    if (q.bit_cnt == LAST_BIT) begin
                        d.result = fmt(raw_n, q.ic, q.fm);
                        d.irq = 1'b1;
                        irq_ev = 1'b1;
                        d.stage = ST_IDLE;
                        if (q.double_sample_en && !q.second) begin
                            d.second = 1'b1;
                            do_start = 1'b1;
                        end else begin
                            d.second = 1'b0;
                            d.done = 1'b1;
                            if (q.continuous_retrigger && !(q.stop_on_interrupt && THRESH_IRQ_IN)) begin
                                do_start = 1'b1;
                            end else begin
                                d.go = 1'b0;
                            end
                        end
                    end
                end
                default: begin
                    d.stage = ST_IDLE;
                end
            endcase
        end
        // computation works on the result that has just been formed
        acc_sum = {1'b0, q.acc} + {3'h0, d.result};
        lp_diff = $signed({1'b0, d.result}) - $signed({1'b0, q.filt});
        lp_step = lp_diff >>> q.crs;
        // computation at the end of a sample or a pair
        if (d.done && !q.accum_clear) begin
            case (q.md)
                MD_ACCUM, MD_AVG, MD_BURST: begin
                    d.acc = acc_sum[17:0];
                    d.cnt = 8'(q.cnt + 8'h01);
                    d.filt = 16'(acc_sum[17:0] >> q.crs);
                    if (acc_sum[18]) begin
                        d.accum_overflow = 1'b1;
                    end
                end
                MD_LPF: begin
                    d.filt = 16'(q.filt + lp_step[15:0]);
                end
                default: begin
                    d.filt = q.filt;
                end
            endcase
        end
        // software writes take effect on the acknowledging edge
        if (wr) begin
            if (idx == IDX_MAIN) begin
                d.on = wdat[BIT_ON];
                d.continuous_retrigger = wdat[BIT_CONTINUOUS_RETRIGGER];
                d.cs = wdat[BIT_CS];
                d.fm = wdat[BIT_FM +: 2];
                d.ic = wdat[BIT_IC];
                if (!wdat[BIT_ON]) begin
                    d.go = 1'b0;
                end else if (wdat[BIT_GO] && q.stage == ST_IDLE) begin
                    d.go = 1'b1;
                    d.second = 1'b0;
                    do_start = 1'b1;
                end else if (!wdat[BIT_GO]) begin
                    d.go = 1'b0;
                end
                if (!d.go && q.stage != ST_IDLE) begin
                    d.result = fmt(q.raw, q.ic, q.fm);
                    d.irq = q.irq;
                    d.done = 1'b0;
                    d.acc = q.acc;
                    d.cnt = q.cnt;
                    d.filt = q.filt;
                    d.accum_overflow = q.accum_overflow;
                    d.second = 1'b0;
                    do_start = 1'b0;
                    d.stage = ST_IDLE;
                end
            end else if (idx == IDX_GUARD) begin
                d.precharge_polarity = wdat[BIT_PRECHARGE_POLARITY];
                d.inverted_precharge_en = wdat[BIT_INVERTED_PRECHARGE_EN];
                d.guard_polarity = wdat[BIT_GUARD_POLARITY];
                d.precharge_cap_only = wdat[BIT_PRECHARGE_CAP_ONLY];
                d.double_sample_en = wdat[BIT_DOUBLE_SAMPLE_EN];
            end else if (idx == IDX_COMP) begin
                d.prev_source_sel = wdat[BIT_PREV_SOURCE_SEL];
                d.crs = wdat[BIT_CRS +: 3];
                d.md = wdat[BIT_MD +: 3];
                if (wdat[BIT_ACCUM_CLEAR]) begin
                    d.accum_clear = 1'b1;
                end
            end else if (idx == IDX_PRE) begin
                d.pre_time = wdat;
            end else if (idx == IDX_CLKDIV) begin
                d.clk_div = wdat[5:0];
            end else if (idx == IDX_AUX) begin
                d.stop_on_interrupt = wdat[BIT_SOI];
            end else if (idx == IDX_STAT) begin
                // write one clears; a completion this cycle wins
                if (wdat[BIT_IRQ] && !irq_ev) begin
                    d.irq = 1'b0;
                end
            end
        end
        // start of a conversion: previous result, precharge setup
        pol = (d.second && q.double_sample_en && q.inverted_precharge_en) ? ~q.precharge_polarity : q.precharge_polarity;
        gpl = (d.second && q.double_sample_en && q.inverted_precharge_en) ? ~q.guard_polarity : q.guard_polarity;
        if (do_start) begin
            d.prev = q.prev_source_sel ? q.filt : d.result;
            d.raw = 12'h000;
            d.grd_b = gpl;
            if (q.pre_time != 8'h00) begin
                d.stage = ST_PRE;
                d.tick_cnt = q.pre_time;
                d.cap_pre = 1'b1;
                d.cap_lvl = ~pol;
                d.pin_o = pol;
                d.pin_oe_n = q.precharge_cap_only;
                d.smp_con = 1'b0;
                d.grd_a = gpl;
            end else begin
                d.stage = ST_ACQ;
                d.tick_cnt = ACQ_TICKS;
                d.cap_pre = 1'b0;
                d.pin_oe_n = 1'b1;
                d.smp_con = 1'b1;
                d.grd_a = ~gpl;
            end
        end else if (d.stage == ST_IDLE) begin
            d.cap_pre = 1'b0;
            d.pin_oe_n = 1'b1;
            d.smp_con = 1'b0;
            d.grd_a = 1'b0;
            d.grd_b = 1'b0;
        end
    end

    // state register with synchronous reset
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            q <= '0;
            q.on <= RST_MAIN[BIT_ON];
            q.ic <= RST_MAIN[BIT_IC];
            q.pre_time <= RST_PRE;
            q.clk_div <= RST_CLKDIV;
            q.pin_oe_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // outputs straight from flip-flops
    assign WB_DAT_O = {24'h000000, q.rdata};
    assign WB_ACK_O = q.ack;
    assign CONV_ACTIVE = q.go;
    assign CAP_PRECHARGE = q.cap_pre;
    assign CAP_LEVEL = q.cap_lvl;
    assign SAMPLE_CONNECT = q.smp_con;
    assign ANA_PIN_O = q.pin_o;
    assign ANA_PIN_OE_N = q.pin_oe_n;
    assign GUARD_A = q.grd_a;
    assign GUARD_B = q.grd_b;

    // checks on the sequencer and register behaviour
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (SYS_RST);

    // write to the main register carrying enable and go
    sequence s_sw_start;
        req && q.ack && WB_WE_I && WB_SEL_I[0] && idx == IDX_MAIN
            && WB_DAT_I[BIT_ON] && WB_DAT_I[BIT_GO] && q.stage == ST_IDLE;
    endsequence
    // write to the main register clearing go during a conversion
    sequence s_sw_abort;
        req && q.ack && WB_WE_I && WB_SEL_I[0] && idx == IDX_MAIN
            && !WB_DAT_I[BIT_GO] && q.stage != ST_IDLE;
    endsequence

    chk_go_needs_on: assert property (q.go |-> q.on)
        else $error("go set while converter disabled");
    chk_start_runs: assert property (s_sw_start |=>
        (q.go && q.stage != ST_IDLE))
        else $error("start write did not begin a conversion");
    chk_off_no_go: assert property ((wr && idx == IDX_MAIN
        && !WB_DAT_I[BIT_ON]) |=> (!q.go && q.stage == ST_IDLE))
        else $error("start accepted while disabled");
    chk_abort_quiet: assert property (s_sw_abort |=>
        (q.stage == ST_IDLE && q.irq == $past(q.irq) && !q.done))
        else $error("abort did not reset or set the flag");
    chk_oneshot_clear: assert property ((q.done && !q.continuous_retrigger) |->
        !q.go)
        else $error("go left set after one-shot conversion");
    chk_pre_skip: assert property ((q.stage == ST_PRE) |->
        (q.pre_time != 8'h00 || $past(q.stage) == ST_PRE))
        else $error("precharge entered with zero time");
    chk_pin_opposite: assert property ((q.stage == ST_PRE
        && !q.pin_oe_n) |-> (q.cap_lvl == !q.pin_o && q.cap_pre))
        else $error("pin and cap precharge levels not opposite");
    chk_cap_only: assert property (($rose(q.cap_pre) && q.precharge_cap_only)
        |-> q.pin_oe_n)
        else $error("pin driven in cap-only precharge");
    chk_accum_clear_done: assert property (q.accum_clear |=>
        (!q.accum_clear && q.cnt == 8'h00 && !q.accum_overflow) [*2])
        else $error("accumulator clear did not finish");
    chk_resv_zero: assert property ((q.ack && idx == IDX_GUARD
        && !WB_WE_I) |-> WB_DAT_O[4:2] == 3'h0)
        else $error("reserved bits read nonzero");
endmodule

// ===== test/afe_model.sv
// analog front end model: rc oscillator, comparator bits, threshold flag
`timescale 1ns/1ps
module afe_model (
    // conversion state seen from the block
    input wire logic active,
    // bench controls
    input wire logic level,
    input wire logic irq,
    // toward the block
    output logic rc_osc,
    output logic comp_bit,
    output logic thresh
);
    // free-running oscillator, 60 ns period, phase unrelated to the clock
    initial begin
        rc_osc = 1'b0;
        #7;
        forever #30 rc_osc = ~rc_osc;
    end
    // inverse level outside conversions so stale samples show up
    assign comp_bit = active ? level : ~level;
    // threshold flag as the bench commands
    assign thresh = irq;
endmodule

// ===== test/adc_control_config_tb.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
module adc_control_config_tb;
    import adc_ctrl_pkg::*;
    logic clk, rst, cyc, stb, we, ack, rc, comp, thr, act, pre, cap_lvl;
    logic smp, pin_o, pin_oe_n, ga, gb, lvl, irq, g2, pre_seen;
    logic [15:0] adr, w;
    logic [3:0] sel;
    logic [31:0] dat_i, dat_o;
    logic [7:0] q;
    int np;
    int failures = 0;
    int n_compared = 0;
    // format table: main register value and expected result
    logic [7:0] fm_cfg [6] = '{8'h85, 8'h8D, 8'h81, 8'h87, 8'h83, 8'h8B};
    logic [15:0] fm_exp [6] = '{16'h0FFF, 16'h0FFF, 16'hFFF0, 16'hFFFF,
        16'hFFF0, 16'h8010};
    adc_ctrl dut (.SYS_CLK(clk), .SYS_RST(rst), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
        .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
        .RC_OSC_IN(rc), .COMP_BIT_IN(comp), .THRESH_IRQ_IN(thr),
        .CONV_ACTIVE(act), .CAP_PRECHARGE(pre), .CAP_LEVEL(cap_lvl),
        .SAMPLE_CONNECT(smp), .ANA_PIN_O(pin_o), .ANA_PIN_OE_N(pin_oe_n),
        .GUARD_A(ga), .GUARD_B(gb));
    afe_model afe (.active(act), .level(lvl), .irq(irq), .rc_osc(rc),
        .comp_bit(comp), .thresh(thr));
    // 50 MHz system clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // compare and count
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // one classic wishbone cycle; read byte lands in q
    task automatic wb(input logic wr, input logic [13:0] a,
        input logic [7:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= wr;
        adr <= {a, 2'b00};
        dat_i <= {24'h000000, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = dat_o[7:0];
        if (n >= 50) failures++;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask
    // sixteen-bit value from a low/high byte pair
    task automatic rd16(input logic [13:0] a);
        wb(1'b0, a, 8'h00);
        w[7:0] = q;
        wb(1'b0, a + 14'h0001, 8'h00);
        w[15:8] = q;
    endtask
    // write main register, let the start settle
    task automatic start(input logic [7:0] d);
        wb(1'b1, IDX_MAIN, d);
        repeat (2) @(posedge clk);
    endtask
    // wait for the converter to go idle, noting precharge entries
    task automatic wait_idle();
        int n;
        logic prv;
        n = 0;
        np = 0;
        prv = 1'b0;
        pre_seen = 1'b0;
        while (act !== 1'b0 && n < 3000) begin
            @(posedge clk);
            #1;
            if (pre === 1'b1 && !prv) begin
                np++;
                if (np == 2) g2 = gb;
            end
            prv = pre;
            pre_seen = pre_seen | pre;
            n++;
        end
        if (n >= 3000) failures++;
        @(posedge clk);
    endtask
    // reset values, masked bits, unmapped place, start while off
    task automatic t_regs();
        wb(1'b0, IDX_MAIN, 8'h00);
        check(q, RST_MAIN);
        wb(1'b1, 14'h0000, 8'hFF);
        wb(1'b0, 14'h0000, 8'h00);
        check(q, 8'h00);
        wb(1'b1, IDX_GUARD, 8'hFF);
        wb(1'b0, IDX_GUARD, 8'h00);
        check(q, 8'hE3);
        wb(1'b1, IDX_GUARD, 8'h00);
        start(8'h21);
        check(act, 1'b0);
        wb(1'b0, IDX_MAIN, 8'h00);
        check(q, 8'h00);
    endtask
    // all result formats but differential code 11, go readback and one-shot clearing
    task automatic t_format();
        lvl <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            start(fm_cfg[i]);
            wb(1'b0, IDX_MAIN, 8'h00);
            check(q, fm_cfg[i]);
            wait_idle();
            wb(1'b0, IDX_MAIN, 8'h00);
            check(q, fm_cfg[i] & 8'hFE);
            rd16(IDX_RES_L);
            check(w, fm_exp[i]);
        end
        lvl <= 1'b0;
        start(8'h85);
        wait_idle();
        rd16(IDX_PREV_L);
        check(w, 16'h8010);
    endtask
    // abort mid-conversion raises no flag; a full one does
    task automatic t_abort();
        wb(1'b1, IDX_STAT, 8'h01);
        start(8'h85);
        wb(1'b1, IDX_MAIN, 8'h84);
        repeat (2) @(posedge clk);
        check(act, 1'b0);
        wb(1'b0, IDX_STAT, 8'h00);
        check(q[0], 1'b0);
        start(8'h85);
        wait_idle();
        wb(1'b0, IDX_STAT, 8'h00);
        check(q[0], 1'b1);
    endtask
    // continuous retrigger: software stop, then stop on threshold
    task automatic t_continuous_retrigger();
        start(8'hC5);
        repeat (200) @(posedge clk);
        check(act, 1'b1);
        start(8'hC4);
        check(act, 1'b0);
        wb(1'b1, IDX_AUX, 8'h01);
        irq <= 1'b1;
        start(8'hC5);
        wait_idle();
        wb(1'b0, IDX_MAIN, 8'h00);
        check(q, 8'hC4);
        irq <= 1'b0;
        wb(1'b1, IDX_AUX, 8'h00);
    endtask
    // slow divided clock versus the dedicated oscillator
    task automatic t_clock();
        wb(1'b1, IDX_CLKDIV, 8'h3F);
        start(8'h85);
        repeat (900) @(posedge clk);
        check(act, 1'b1);
        wait_idle();
        start(8'h95);
        repeat (150) @(posedge clk);
        check(act, 1'b0);
        wb(1'b1, IDX_CLKDIV, 8'h00);
    endtask
    // precharge levels, guard start, cap-only, zero precharge time
    task automatic t_precharge();
        int n;
        logic p;
        wb(1'b1, IDX_PRE, 8'h05);
        for (int k = 0; k < 3; k++) begin
            p = (k != 0);
            wb(1'b1, IDX_GUARD, k == 0 ? 8'h00 : (k == 1 ? 8'hA0 : 8'hA2));
            start(8'h85);
            n = 0;
            while (pre !== 1'b1 && n < 50) begin
                @(posedge clk);
                #1;
                n++;
            end
            check(cap_lvl, !p);
            if (k < 2) check(pin_o, p);
            check(pin_oe_n, k == 2);
            check({ga, gb}, {p, p});
            wait_idle();
        end
        wb(1'b1, IDX_GUARD, 8'h00);
        wb(1'b1, IDX_PRE, 8'h00);
        start(8'h85);
        wait_idle();
        check(pre_seen, 1'b0);
    endtask
    // double sampling pairs, with and without inverted second precharge
    task automatic t_double();
        wb(1'b1, IDX_PRE, 8'h05);
        for (int k = 0; k < 2; k++) begin
            wb(1'b1, IDX_GUARD, k == 0 ? 8'h61 : 8'h21);
            start(8'h85);
            wait_idle();
            check(16'(np), 16'h0002);
            check(g2, k == 1);
        end
        wb(1'b1, IDX_GUARD, 8'h00);
        wb(1'b1, IDX_PRE, 8'h00);
    endtask
    // accumulate mode with shift of two after a clear
    task automatic t_accum();
        wb(1'b1, IDX_COMP, 8'h29);
        wb(1'b0, IDX_COMP, 8'h00);
        check(q, 8'h21);
        lvl <= 1'b1;
        start(8'h85);
        wait_idle();
        rd16(IDX_FILT_L);
        check(w, 16'h03FF);
        // low-pass filter, shift one: halfway toward the new result
        wb(1'b1, IDX_COMP, 8'h14);
        start(8'h85);
        wait_idle();
        rd16(IDX_FILT_L);
        check(w, 16'h09FF);
        // basic mode with a large shift leaves the filter alone
        wb(1'b1, IDX_COMP, 8'h60);
        start(8'h85);
        wait_idle();
        rd16(IDX_FILT_L);
        check(w, 16'h09FF);
    endtask
    // counts, verdict, end of run
    task automatic print_verdict();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // watchdog far beyond the expected run length
    initial begin
        #400000;
        failures++;
        print_verdict();
    end
    // main sequence
    initial begin
        rst = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 16'h0000;
        sel = 4'hF;
        dat_i = 32'h00000000;
        lvl = 1'b0;
        irq = 1'b0;
        g2 = 1'b0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_format();
        t_abort();
        t_continuous_retrigger();
        t_clock();
        t_precharge();
        t_double();
        t_accum();
        print_verdict();
    end
endmodule
